// >>> hw/ddcm_top.v
// Two-channel mixer and numeric oscillator control with AHB-Lite registers and I/Q output streams
// Function
// R1 - Gain code 00 adds nothing, 01 adds 3 dB, 10 adds 6 dB; 11 unused.
// R2 - Toggling a reload bit zeroes that oscillator phase and loads the new frequency.
// R3 - Reload bit keeps the written value; software writes it back to toggle.
// R4 - Quarter-rate enable mixes at sample rate over four, complex decimation only.
// R5 - Swap bit 0 sends I then Q; 1 sends Q then I.
// R6 - Q-delay bit 1 pairs I[n] with Q[n+1]; 0 keeps I[n], Q[n].
// R7 - Quarter-mix phase bit 1 inverts mixer phase while quarter-rate mixing.
// R8 - Channel A frequency word is four bytes, lowest first, f times 2^32 over rate.
// R9 - Real decimation forces the frequency word registers to zero.
// R10 - Channel B has its own swap, Q-delay and quarter-phase controls.
// R11 - Channel B gain field sits in bits 3-2, same encoding.
// R12 - Real-output bit 1 gives low-pass only without mixing; 0 complex.
// R13 - Mix-phase bit 1 inverts the oscillator phase.
// R14 - Software writes zero to reserved bits and expects no function from them.
// R15 - All mixer and oscillator controls are zero after reset.
`timescale 1ns/1ps
`include "ddcm_consts.vh"
module ddcm_top #(
  parameter SW = 14,
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire [31:0] osc_freq_word_second,
  input wire [SW-1:0] sample_a,
  input wire sample_a_valid,
  output wire sample_a_ready,
  input wire [SW-1:0] sample_b,
  input wire sample_b_valid,
  output wire sample_b_ready,
  output wire [SW+1:0] iq_a,
  output wire iq_a_valid,
  input wire iq_a_ready,
  output wire [SW+1:0] iq_b,
  output wire iq_b_valid,
  input wire iq_b_ready
);
  localparam OW = SW + 2;
  localparam ST_IDLE = 3'b001;
  localparam ST_FIRST = 3'b010;
  localparam ST_SECOND = 3'b100;

  // Register file
  reg [7:0] glob_q;
  reg [7:0] mix_q;
  reg [7:0] ord_a_q;
  reg [7:0] ord_b_q;
  reg [31:0] freq_a_q;
  reg dp_wr_q;
  reg [7:0] dp_idx_q;
  reg [7:0] rd_mux;
  wire real_out;
  wire mix_phase;

  // Gain after the mixer; 3 dB is taken as 1.375, the nearest cheap shift-add
  function [OW-1:0] apply_gain;
    input [OW-1:0] x;
    input [1:0] code;
    begin
      case (code)
        `DDCM_GAIN_3DB: apply_gain = x + {{3{x[OW-1]}}, x[OW-1:3]} + {{2{x[OW-1]}}, x[OW-1:2]}; // [R1]
        `DDCM_GAIN_6DB: apply_gain = {x[OW-2:0], 1'b0}; // [R1]
        default: apply_gain = x; // [R1]
      endcase
    end
  endfunction

  // Coarse quadrature mixer: the top two phase bits pick cos and sin from {1,0,-1,0}
  function [2*OW-1:0] mix_quadrant;
    input [OW-1:0] x;
    input [1:0] quad;
    reg [OW-1:0] nx;
    begin
      nx = {OW{1'b0}} - x;
      case (quad)
        2'h1: mix_quadrant = {{OW{1'b0}}, nx};
        2'h2: mix_quadrant = {nx, {OW{1'b0}}};
        2'h3: mix_quadrant = {{OW{1'b0}}, x};
        default: mix_quadrant = {x, {OW{1'b0}}};
      endcase
    end
  endfunction

  assign real_out = glob_q[`DDCM_BIT_REAL_OUT];
  assign mix_phase = glob_q[`DDCM_BIT_MIX_PHASE];

  // Zero-wait slave: never stalls, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = `DDCM_HRESP_OKAY;
  assign hrdata = {24'h000000, rd_mux};

  // Address phase capture; only word-aligned addresses decode to registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      dp_idx_q <= 8'h00;
    end else if (hready) begin
      dp_wr_q <= hsel & htrans[1] & hwrite;
      dp_idx_q <= (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0) ? haddr[9:2] : 8'hFF;
    end
  end

  // Read mux; unmapped words and reserved bits read as zero
  always @* begin
    case (dp_idx_q)
      `DDCM_IDX_GLOBAL_CTRL: rd_mux = glob_q & 8'h09;
      `DDCM_IDX_MIX_CTRL: rd_mux = mix_q;
      `DDCM_IDX_ORDER_A: rd_mux = ord_a_q & 8'h1C;
      `DDCM_IDX_FREQ_B0: rd_mux = freq_a_q[7:0]; // [R8]
      `DDCM_IDX_FREQ_B1: rd_mux = freq_a_q[15:8];
      `DDCM_IDX_FREQ_B2: rd_mux = freq_a_q[23:16];
      `DDCM_IDX_FREQ_B3: rd_mux = freq_a_q[31:24];
      `DDCM_IDX_ORDER_B: rd_mux = ord_b_q & 8'h1C;
      default: rd_mux = 8'h00;
    endcase
  end

  // Data phase writes; reserved bits are dropped since software must write them as zero [R14]
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      glob_q <= `DDCM_RST_BYTE; // [R15]
      mix_q <= `DDCM_RST_BYTE; // [R15]
      ord_a_q <= `DDCM_RST_BYTE; // [R15]
      ord_b_q <= `DDCM_RST_BYTE; // [R15]
      freq_a_q <= `DDCM_RST_WORD; // [R15]
    end else begin
      if (dp_wr_q) begin
        case (dp_idx_q)
          `DDCM_IDX_GLOBAL_CTRL: glob_q <= hwdata[7:0] & 8'h09; // [R12] [R13]
          `DDCM_IDX_MIX_CTRL: mix_q <= hwdata[7:0]; // [R3]
          `DDCM_IDX_ORDER_A: ord_a_q <= hwdata[7:0] & 8'h1C;
          `DDCM_IDX_FREQ_B0: freq_a_q[7:0] <= hwdata[7:0]; // [R8]
          `DDCM_IDX_FREQ_B1: freq_a_q[15:8] <= hwdata[7:0]; // [R8]
          `DDCM_IDX_FREQ_B2: freq_a_q[23:16] <= hwdata[7:0]; // [R8]
          `DDCM_IDX_FREQ_B3: freq_a_q[31:24] <= hwdata[7:0]; // [R8]
          `DDCM_IDX_ORDER_B: ord_b_q <= hwdata[7:0] & 8'h1C; // [R10]
          default: ;
        endcase
      end
      // Real mode wins over any write of the same cycle
      if (real_out) begin
        freq_a_q <= `DDCM_RST_WORD; // [R9]
      end
    end
  end

  // Per-channel views of the control fields
  wire [1:0] gain_c [0:1];
  wire reload_c [0:1];
  wire qmix_c [0:1];
  wire swap_c [0:1];
  wire qdel_c [0:1];
  wire qinv_c [0:1];
  wire [31:0] word_c [0:1];
  wire [SW-1:0] smp_c [0:1];
  wire smp_valid_c [0:1];
  wire smp_ready_c [0:1];
  wire [OW-1:0] out_data_c [0:1];
  wire out_valid_c [0:1];
  wire out_ready_c [0:1];
  wire [OW-1:0] fifo_in_c [0:1];
  wire fifo_in_valid_c [0:1];
  wire fifo_in_ready_c [0:1];

  assign gain_c[0] = mix_q[`DDCM_POS_GAIN_A+1:`DDCM_POS_GAIN_A];
  assign gain_c[1] = mix_q[`DDCM_POS_GAIN_B+1:`DDCM_POS_GAIN_B]; // [R11]
  assign reload_c[0] = mix_q[`DDCM_BIT_RELOAD_A];
  assign reload_c[1] = mix_q[`DDCM_BIT_RELOAD_B];
  assign qmix_c[0] = mix_q[`DDCM_BIT_QMIX_A];
  assign qmix_c[1] = mix_q[`DDCM_BIT_QMIX_B];
  assign swap_c[0] = ord_a_q[`DDCM_BIT_SWAP];
  assign swap_c[1] = ord_b_q[`DDCM_BIT_SWAP]; // [R10]
  assign qdel_c[0] = ord_a_q[`DDCM_BIT_QDEL];
  assign qdel_c[1] = ord_b_q[`DDCM_BIT_QDEL]; // [R10]
  assign qinv_c[0] = ord_a_q[`DDCM_BIT_QINV];
  assign qinv_c[1] = ord_b_q[`DDCM_BIT_QINV]; // [R10]
  assign word_c[0] = freq_a_q;
  assign word_c[1] = real_out ? `DDCM_RST_WORD : osc_freq_word_second; // [R9]
  assign smp_c[0] = sample_a;
  assign smp_c[1] = sample_b;
  assign smp_valid_c[0] = sample_a_valid;
  assign smp_valid_c[1] = sample_b_valid;
  assign sample_a_ready = smp_ready_c[0];
  assign sample_b_ready = smp_ready_c[1];
  assign iq_a = out_data_c[0];
  assign iq_b = out_data_c[1];
  assign iq_a_valid = out_valid_c[0];
  assign iq_b_valid = out_valid_c[1];
  assign out_ready_c[0] = iq_a_ready;
  assign out_ready_c[1] = iq_b_ready;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      reg [2:0] st_q;
      reg [31:0] phase_q;
      reg [31:0] step_q;
      reg reload_seen_q;
      reg [OW-1:0] i_prev_q;
      reg [OW-1:0] first_q;
      reg [OW-1:0] second_q;
      wire [OW-1:0] xin;
      wire quarter;
      wire invert;
      wire [1:0] quad;
      wire [2*OW-1:0] mixed;
      wire [OW-1:0] i_now;
      wire [OW-1:0] q_now;
      wire [OW-1:0] i_pair;
      wire take;

      // Quarter-rate mixing only exists in complex decimation
      assign quarter = qmix_c[ch] & ~real_out; // [R4]
      // Oscillator inversion, and the extra inversion of the quarter-rate mixer
      assign invert = mix_phase ^ (quarter & qinv_c[ch]); // [R13] [R7]
      assign quad = invert ? 2'h0 - phase_q[31:30] : phase_q[31:30];
      assign xin = {{2{smp_c[ch][SW-1]}}, smp_c[ch]};
      assign mixed = mix_quadrant(xin, quad);
      // Real mode passes the low-pass path straight through with Q at zero
      assign i_now = real_out ? xin : apply_gain(mixed[2*OW-1:OW], gain_c[ch]); // [R12]
      assign q_now = real_out ? {OW{1'b0}} : apply_gain(mixed[OW-1:0], gain_c[ch]); // [R12]
      // With the Q delay the held I of the previous sample pairs with this Q
      assign i_pair = qdel_c[ch] ? i_prev_q : i_now; // [R6]
      assign take = smp_valid_c[ch] & (st_q == ST_IDLE);
      assign smp_ready_c[ch] = (st_q == ST_IDLE);
      assign fifo_in_valid_c[ch] = (st_q == ST_FIRST) | (st_q == ST_SECOND);
      assign fifo_in_c[ch] = (st_q == ST_SECOND) ? second_q : first_q;

      // Oscillator: any change of the reload bit restarts phase and loads the step
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          phase_q <= `DDCM_RST_WORD;
          step_q <= `DDCM_RST_WORD;
          reload_seen_q <= 1'b0;
        end else begin
          reload_seen_q <= reload_c[ch];
          if (reload_seen_q != reload_c[ch]) begin
            phase_q <= `DDCM_RST_WORD; // [R2]
            step_q <= word_c[ch]; // [R2]
          end else if (take) begin
            phase_q <= phase_q + (quarter ? `DDCM_QUARTER_STEP : step_q); // [R4]
          end
        end
      end

      // Serialiser; the FIFO's ready stalls the sample input through the state
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          st_q <= ST_IDLE;
          i_prev_q <= {OW{1'b0}};
          first_q <= {OW{1'b0}};
          second_q <= {OW{1'b0}};
        end else begin
          case (st_q)
            ST_IDLE: begin
              if (take) begin
                i_prev_q <= i_now;
                first_q <= swap_c[ch] ? q_now : i_pair; // [R5]
                second_q <= swap_c[ch] ? i_pair : q_now; // [R5]
                st_q <= ST_FIRST;
              end
            end
            ST_FIRST: begin
              if (fifo_in_ready_c[ch]) begin
                st_q <= ST_SECOND;
              end
            end
            ST_SECOND: begin
              if (fifo_in_ready_c[ch]) begin
                st_q <= ST_IDLE;
              end
            end
            default: st_q <= ST_IDLE;
          endcase
        end
      end

      ddcm_fifo #(
        .WIDTH(OW),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
      ) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_data(fifo_in_c[ch]),
        .in_valid(fifo_in_valid_c[ch]),
        .in_ready(fifo_in_ready_c[ch]),
        .out_data(out_data_c[ch]),
        .out_valid(out_valid_c[ch]),
        .out_ready(out_ready_c[ch])
      );
    end
  endgenerate
endmodule

// >>> hw/ddcm_consts.vh
// Register indices, field positions, gain codes, reset values, quarter step and bus answer of the mixer control block
`ifndef DDCM_CONSTS_VH
`define DDCM_CONSTS_VH

// Register indices; the byte address on the bus is four times the index
`define DDCM_IDX_GLOBAL_CTRL 8'h25
`define DDCM_IDX_MIX_CTRL 8'h26
`define DDCM_IDX_ORDER_A 8'h27
`define DDCM_IDX_FREQ_B0 8'h2A
`define DDCM_IDX_FREQ_B1 8'h2B
`define DDCM_IDX_FREQ_B2 8'h2C
`define DDCM_IDX_FREQ_B3 8'h2D
`define DDCM_IDX_ORDER_B 8'h2E

// Global control fields
`define DDCM_BIT_REAL_OUT 3
`define DDCM_BIT_MIX_PHASE 0

// Mixer control fields, channel A high nibble, channel B low nibble
`define DDCM_POS_GAIN_A 6
`define DDCM_BIT_RELOAD_A 5
`define DDCM_BIT_QMIX_A 4
`define DDCM_POS_GAIN_B 2
`define DDCM_BIT_RELOAD_B 1
`define DDCM_BIT_QMIX_B 0

// Order control fields, same layout for both channels
`define DDCM_BIT_SWAP 4
`define DDCM_BIT_QDEL 3
`define DDCM_BIT_QINV 2

// Gain codes
`define DDCM_GAIN_0DB 2'h0
`define DDCM_GAIN_3DB 2'h1
`define DDCM_GAIN_6DB 2'h2

// Reset values
`define DDCM_RST_BYTE 8'h00
`define DDCM_RST_WORD 32'h00000000

// Phase step of a quarter of the sample rate: two to the thirtieth
`define DDCM_QUARTER_STEP 32'h40000000

// Fixed bus answer
`define DDCM_HRESP_OKAY 1'b0

`endif

// >>> hw/ddcm_fifo.v
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module ddcm_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire hclk,
  input wire hresetn,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  // Honest flags from the fill count
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage is not reset; only the pointers and the fill count carry state
  always @(posedge hclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap at DEPTH so non-power-of-two depths also work
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// >>> sim/ddcm_chk.sv
// Port-level assertions for the mixer control block
`timescale 1ns/1ps
module ddcm_chk #(parameter SW = 14) (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire sample_a_valid,
  input wire sample_a_ready,
  input wire sample_b_valid,
  input wire sample_b_ready,
  input wire [SW+1:0] iq_a,
  input wire iq_a_valid,
  input wire iq_a_ready,
  input wire [SW+1:0] iq_b,
  input wire iq_b_valid,
  input wire iq_b_ready
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bus never stalls and never errors
  a_bus_never_waits: assert property (hreadyout && hresp == 1'b0) else $error("bus answer not ready or not okay");
  a_upper_bytes_zero: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
  // A taken sample blocks the channel until both words are stored
  a_busy_after_a: assert property (sample_a_valid && sample_a_ready |=> !sample_a_ready [*2])
    else $error("channel A ready too soon");
  a_busy_after_b: assert property (sample_b_valid && sample_b_ready |=> !sample_b_ready [*2])
    else $error("channel B ready too soon");
  a_words_appear_a: assert property (sample_a_valid && sample_a_ready |-> ##[1:4] iq_a_valid)
    else $error("channel A words missing");
  // Busy channel A with empty buffer must free up quickly
  a_ready_returns_a: assert property (!sample_a_ready && !iq_a_valid |-> ##[0:3] sample_a_ready)
    else $error("channel A stuck busy");
  // Stalled output words must hold, otherwise pairs get torn
  a_hold_word_a: assert property (iq_a_valid && !iq_a_ready |=> iq_a_valid && $stable(iq_a))
    else $error("channel A word changed while stalled");
  a_hold_word_b: assert property (iq_b_valid && !iq_b_ready |=> iq_b_valid && $stable(iq_b))
    else $error("channel B word changed while stalled");
endmodule
bind ddcm_top ddcm_chk #(.SW(SW)) u_ddcm_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .sample_a_valid(sample_a_valid), .sample_a_ready(sample_a_ready),
  .sample_b_valid(sample_b_valid), .sample_b_ready(sample_b_ready), .iq_a(iq_a), .iq_a_valid(iq_a_valid),
  .iq_a_ready(iq_a_ready), .iq_b(iq_b), .iq_b_valid(iq_b_valid), .iq_b_ready(iq_b_ready));

// >>> sim/ddcm_tb.sv
// Self-checking bench for the mixer control block
`timescale 1ns/1ps
`include "ddcm_consts.vh"
module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sav = 0, sbv = 0, iar = 0, ibr = 0, stall = 0;
  logic [31:0] haddr = 0, hwdata = 0, ob = 0, ph[2] = '{0, 0}, stp[2] = '{0, 0};
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [13:0] sa = 0, sb = 0;
  logic [7:0] r25 = 0, r26 = 0, rd, wv, ro[2] = '{8'h00, 8'h00};
  logic [7:0] regs[8] = '{8'h25, 8'h26, 8'h27, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E};
  logic [7:0] msk[8] = '{8'h09, 8'hFF, 8'h1C, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1C};
  wire hreadyout, hresp, sar, sbr, iav, ibv;
  wire [31:0] hrdata;
  wire [15:0] iqa, iqb;
  int err_total = 0, tests_run = 0, seed = 58787, n, qs[2][$], prv[2] = '{0, 0};
  always #2 hclk = ~hclk;
  ddcm_top u_ddcm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .osc_freq_word_second(ob), .sample_a(sa), .sample_a_valid(sav), .sample_a_ready(sar),
    .sample_b(sb), .sample_b_valid(sbv), .sample_b_ready(sbr), .iq_a(iqa), .iq_a_valid(iav), .iq_a_ready(iar),
    .iq_b(iqb), .iq_b_valid(ibv), .iq_b_ready(ibr));
  task check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Bounded wait for the slave answer; a hang ends the run
  task hold_ready;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hold_ready;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    hold_ready;
    rd = hrdata[7:0];
  endtask
  task rdchk(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    check({24'h0, rd}, {24'h0, e});
  endtask
  // Gain of the model; samples are multiples of eight so the 3 dB step is exact
  function automatic int gn(input int v, input int g);
    return g == 1 ? v * 11 / 8 : (g == 2 ? 2 * v : v);
  endfunction
  // Model of one sample: oscillator quadrant, inversion, gain, real mode, delayed pairing and swap
  task send(input int ch, input int x);
    int i, q, g, w0, qd, qm;
    g = ch ? r26[3:2] : r26[7:6];
    qm = (ch ? r26[0] : r26[4]) && !r25[3];
    qd = ph[ch][31:30];
    if (r25[0] ^ (qm && ro[ch][2])) qd = (4 - qd) & 3;
    ph[ch] += qm ? `DDCM_QUARTER_STEP : stp[ch];
    i = r25[3] ? x : gn(qd == 0 ? x : (qd == 2 ? -x : 0), g);
    q = r25[3] ? 0 : gn(qd == 1 ? -x : (qd == 3 ? x : 0), g);
    w0 = ro[ch][3] ? prv[ch] : i;
    prv[ch] = i;
    qs[ch].push_back(ro[ch][4] ? q : w0);
    qs[ch].push_back(ro[ch][4] ? w0 : q);
    @(posedge hclk);
    n = 0;
    while ((ch ? sbr : sar) !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      tally_and_finish;
    end
    if (ch) {sbv, sb} <= {1'b1, x[13:0]};
    else {sav, sa} <= {1'b1, x[13:0]};
    @(posedge hclk);
    sav <= 1'b0;
    sbv <= 1'b0;
  endtask
  task mon(input int ch, input logic [15:0] v);
    if (qs[ch].size() == 0) begin
      err_total++;
      $display("BAD %0t unexpected word", $time);
    end else check({16'h0, v}, qs[ch].pop_front() & 32'hFFFF);
  endtask
  // Random sink readiness; stall holds both sinks off
  always @(posedge hclk) begin
    iar <= !stall && ($random(seed) % 3 != 0);
    ibr <= !stall && ($random(seed) % 3 != 0);
    if (iav === 1'b1 && iar === 1'b1) mon(0, iqa);
    if (ibv === 1'b1 && ibr === 1'b1) mon(1, iqb);
  end
  task fin(input string s);
    n = 0;
    while (qs[0].size() + qs[1].size() > 0 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 500) begin
      err_total++;
      tally_and_finish;
    end
    $display("test %s done", s);
  endtask
  function automatic int rnd8();
    return ($random(seed) % 1024) * 8;
  endfunction
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 8; k++) rdchk(regs[k], 8'h00);
    rdchk(8'h28, 8'h00);
    fin("reset");
    ob <= $random(seed);
    // Real mode from the first random write forces the frequency bytes to zero
    for (int k = 0; k < 8; k++) begin
      wv = $random(seed);
      bus(1'b1, regs[k], wv);
      if (k == 0) r25 = wv;
      rdchk(regs[k], (k > 2 && k < 7 && r25[3]) ? 8'h00 : wv & msk[k]);
    end
    // Clear everything, then toggle both reloads so phase and step return to zero
    ob <= 32'h0;
    for (int k = 0; k < 8; k++) bus(1'b1, regs[k], 8'h00);
    bus(1'b1, `DDCM_IDX_MIX_CTRL, 8'h22);
    bus(1'b1, `DDCM_IDX_MIX_CTRL, 8'h00);
    fin("registers");
    r25 = 8'h08;
    r26 = 8'h88;
    bus(1'b1, `DDCM_IDX_GLOBAL_CTRL, r25);
    bus(1'b1, `DDCM_IDX_MIX_CTRL, r26);
    bus(1'b1, `DDCM_IDX_FREQ_B0, 8'h5A);
    rdchk(`DDCM_IDX_FREQ_B0, 8'h00);
    send(0, rnd8());
    send(1, rnd8());
    r25 = 8'h00;
    bus(1'b1, `DDCM_IDX_GLOBAL_CTRL, r25);
    fin("real");
    for (int g = 0; g < 4; g++) begin
      r26 = {g[1:0], 2'h0, g[1:0], 2'h0};
      bus(1'b1, `DDCM_IDX_MIX_CTRL, r26);
      repeat (3) begin
        send(0, rnd8());
        send(1, rnd8());
      end
    end
    r26 = 8'h00;
    bus(1'b1, `DDCM_IDX_MIX_CTRL, r26);
    fin("gain");
    for (int m = 0; m < 4; m++) begin
      ro[0] = {3'h0, m[1:0], 3'h0};
      ro[1] = ro[0];
      bus(1'b1, `DDCM_IDX_ORDER_A, ro[0]);
      bus(1'b1, `DDCM_IDX_ORDER_B, ro[1]);
      repeat (3) begin
        send(0, rnd8());
        send(1, rnd8());
      end
    end
    fin("order");
    // Quarter-rate mixing walks the four quadrants; four samples bring the phase back to zero
    r26 = 8'h51;
    bus(1'b1, `DDCM_IDX_MIX_CTRL, r26);
    for (int m = 0; m < 4; m++) begin
      r25 = {7'h0, m[0]};
      ro[0] = {5'h0, m[1], 2'h0};
      ro[1] = ro[0];
      bus(1'b1, `DDCM_IDX_GLOBAL_CTRL, r25);
      bus(1'b1, `DDCM_IDX_ORDER_A, ro[0]);
      bus(1'b1, `DDCM_IDX_ORDER_B, ro[1]);
      repeat (4) begin
        send(0, rnd8());
        send(1, rnd8());
      end
    end
    r25 = 8'h00;
    r26 = 8'h00;
    bus(1'b1, `DDCM_IDX_GLOBAL_CTRL, r25);
    bus(1'b1, `DDCM_IDX_MIX_CTRL, r26);
    fin("quarter");
    // A reload toggle loads the new word; half the sample rate flips the sign of I each sample
    for (int s = 0; s < 2; s++) begin
      ob <= s ? 32'h00000000 : 32'h80000000;
      bus(1'b1, `DDCM_IDX_FREQ_B3, s ? 8'h00 : 8'h80);
      bus(1'b1, `DDCM_IDX_MIX_CTRL, 8'h22);
      bus(1'b1, `DDCM_IDX_MIX_CTRL, 8'h00);
      stp[0] = s ? 32'h00000000 : 32'h80000000;
      stp[1] = stp[0];
      ph[0] = 32'h00000000;
      ph[1] = 32'h00000000;
      repeat (2) begin
        send(0, rnd8());
        send(1, rnd8());
      end
    end
    fin("reload");
    // Third sample cannot enter a full buffer, so the channel stays busy
    stall <= 1'b1;
    repeat (3) send(0, rnd8());
    repeat (10) @(posedge hclk);
    check({31'h0, sar}, 32'h0);
    stall <= 1'b0;
    fin("buffer");
    tally_and_finish;
  end
endmodule
